// [hdl/line_maint_pkg.sv]
// Functional notes
// - criterion 0: loss after 175 low bits
// - criterion 1: loss after 1544 low bits
// - clear needs level, 12.5% marks, <100 zeros
// - long haul clears above Q plus 4 dB
// - receive all ones during loss when enabled
// - transmit all ones during loss when enabled
// - violation insert rising edge, one violation
// - criterion 0: AMI >15, B8ZS >8 zeros
// - criterion 1: AMI >80, B8ZS >8 zeros
// - count zero errors only when field is 01
// - manual mode copies counter on transfer edge
// - auto mode copies counter every second
// - transfer bit acts only in manual mode
// - four loopback enables, active while set
// - driver fail and loss flags gated by enables
// - second status flags each gated by enable
// - termination codes; tx 1xx reserved, rx bypass
// - status flag cleared by writing one
// - line code bit: 0 B8ZS, 1 AMI
package line_maint_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_RX_CONFIG      = 6'h28;
  localparam logic [5:0] IDX_RX_LEVEL       = 6'h29;
  localparam logic [5:0] IDX_LOOPBACK       = 6'h2b;
  localparam logic [5:0] IDX_LOS_CRITERIA   = 6'h2c;
  localparam logic [5:0] IDX_ERROR_COUNTING = 6'h31;
  localparam logic [5:0] IDX_TERMINATION    = 6'h32;
  localparam logic [5:0] IDX_LINE_IRQ_EN    = 6'h33;
  localparam logic [5:0] IDX_ERROR_IRQ_EN   = 6'h34;
  localparam logic [5:0] IDX_LINE_STATUS    = 6'h36;
  localparam logic [5:0] IDX_LINE_IRQ_ST    = 6'h3a;
  localparam logic [5:0] IDX_ERROR_IRQ_ST   = 6'h3b;
  localparam logic [5:0] IDX_COUNT_LOW      = 6'h3c;
  localparam logic [5:0] IDX_COUNT_HIGH     = 6'h3d;

  // writable bit masks
  localparam logic [7:0] MASK_RX_CONFIG    = 8'h01;
  localparam logic [7:0] MASK_RX_LEVEL     = 8'h1f;
  localparam logic [7:0] MASK_LOOPBACK     = 8'h17;
  localparam logic [7:0] MASK_LOS_CRITERIA = 8'h1c;
  localparam logic [7:0] MASK_ERROR_COUNT  = 8'h5f;
  localparam logic [7:0] MASK_TERMINATION  = 8'h3f;
  localparam logic [7:0] MASK_LINE_IRQ     = 8'h05;
  localparam logic [7:0] MASK_ERROR_IRQ    = 8'h77;

  // reset values
  localparam logic [7:0] RST_RX_LEVEL    = 8'h15;
  localparam logic [7:0] RST_TERMINATION = 8'h04;

  // field positions
  localparam int BIT_LINE_CODE   = 0;
  localparam int BIT_SYS_REMOTE  = 4;
  localparam int BIT_REMOTE      = 2;
  localparam int BIT_ANALOG      = 1;
  localparam int BIT_DIGITAL2    = 0;
  localparam int BIT_LOSS_CRIT   = 4;
  localparam int BIT_RX_ONES     = 3;
  localparam int BIT_TX_ONES     = 2;
  localparam int BIT_VIOL_INSERT = 6;
  localparam int BIT_ZERO_CRIT   = 4;
  localparam int BIT_ZCNT_HI     = 3;
  localparam int BIT_ZCNT_LO     = 2;
  localparam int BIT_REPORT_MODE = 1;
  localparam int BIT_TRANSFER    = 0;
  localparam int BIT_DRIVER_FAIL = 2;
  localparam int BIT_LOSS        = 0;
  localparam int BIT_TEMPLATE_OV = 6;
  localparam int BIT_TX_SLIP     = 5;
  localparam int BIT_RX_SLIP     = 4;
  localparam int BIT_ZERO_ERR    = 2;
  localparam int BIT_VIOLATION   = 1;
  localparam int BIT_COUNT_OV    = 0;

  // counts in bit intervals
  localparam int             RUN_W          = 11;
  localparam logic [10:0]    LOSS_RUN_SHORT = 11'd175;
  localparam logic [10:0]    LOSS_RUN_LONG  = 11'd1544;
  localparam logic [10:0]    CLEAR_ZERO_RUN = 11'd100;
  localparam logic [6:0]     WINDOW_LAST    = 7'd127;
  localparam logic [7:0]     WINDOW_MARKS   = 8'd16;
  localparam logic [10:0]    ZERO_AMI_ANSI  = 11'd15;
  localparam logic [10:0]    ZERO_AMI_FCC   = 11'd80;
  localparam logic [10:0]    ZERO_B8ZS      = 11'd8;
  localparam logic [1:0]     ZCNT_ENABLE    = 2'b01;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic driver_fail;
    logic template_overflow;
    logic tx_fifo_slip;
    logic rx_fifo_slip;
    logic violation_detect;
  } line_events_t;

  typedef struct packed {
    logic system_remote_loop_en;
    logic remote_loop_en;
    logic analog_loop_en;
    logic local_digital_loop2_en;
  } loop_ctrl_t;

  typedef struct packed {
    logic [2:0] tx_term;
    logic       tx_term_reserved;
    logic [2:0] rx_term;
    logic       rx_term_bypass;
  } term_ctrl_t;

  typedef struct packed {
    logic [RUN_W-1:0] count;
  } run_state_t;

  typedef struct packed {
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [7:0]  w_data;
    logic        w_strb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
    logic [7:0]  rx_config;
    logic [7:0]  rx_level;
    logic [7:0]  loopback;
    logic [7:0]  los_criteria;
    logic [7:0]  error_counting;
    logic [7:0]  termination;
    logic [7:0]  line_irq_en;
    logic [7:0]  error_irq_en;
    logic [7:0]  line_irq_st;
    logic [7:0]  error_irq_st;
    logic        loss_status;
    logic        driver_fail_d;
    logic [15:0] zero_counter;
    logic [15:0] zero_report;
    logic [6:0]  window_pos;
    logic [7:0]  window_marks;
    logic        window_ok;
    logic        viol_pulse;
    logic        rx_data_q;
    logic        tx_data_q;
  } ctrl_state_t;

endpackage : line_maint_pkg

// [hdl/run_counter.sv]
`timescale 1ns/1ps
module run_counter (
  // clock and reset
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic                           ce,
  // run control
  input  wire logic                           step,
  input  wire logic                           restart,
  // run length so far
  output logic [line_maint_pkg::RUN_W-1:0]    count
);

  line_maint_pkg::run_state_t s_reg;
  line_maint_pkg::run_state_t s_next;

  // counts consecutive steps, saturating at full scale
  always_comb begin
    s_next = s_reg;
    if (ce) begin
      if (restart) begin
        s_next.count = '0;
      end else if (step && (s_reg.count != '1)) begin
        s_next.count = s_reg.count + {{(line_maint_pkg::RUN_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign count = s_reg.count;

endmodule : run_counter

// [hdl/line_maintenance_interrupt_ctrl.sv]
`timescale 1ns/1ps
module line_maintenance_interrupt_ctrl (
  // clock, reset, clock enable
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          ce,
  // axi4-lite write address
  input  wire logic [7:0]                    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]                    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // line side inputs
  input  wire logic                          line_bit_en,
  input  wire logic                          rx_level_low,
  input  wire logic                          rx_level_high,
  input  wire logic                          rx_mark,
  input  wire logic                          tx_data_in,
  input  wire logic                          one_sec_tick,
  input  wire line_maint_pkg::line_events_t  line_events,
  // line side outputs
  output logic                               rx_data_out,
  output logic                               tx_data_out,
  output logic                               violation_insert_pulse,
  output line_maint_pkg::loop_ctrl_t         loop_ctrl,
  output line_maint_pkg::term_ctrl_t         term_ctrl,
  output logic [4:0]                         loss_threshold_q,
  output logic                               loss_status,
  output logic                               irq
);

  line_maint_pkg::ctrl_state_t s_reg;
  line_maint_pkg::ctrl_state_t s_next;

  logic [line_maint_pkg::RUN_W-1:0] low_run;
  logic [line_maint_pkg::RUN_W-1:0] zero_run;
  logic                             low_step;
  logic                             low_restart;
  logic                             zero_step;
  logic                             zero_restart;

  // run of bits below the declare threshold
  assign low_step     = line_bit_en & rx_level_low;
  assign low_restart  = line_bit_en & ~rx_level_low;
  // run of received zeros
  assign zero_step    = line_bit_en & ~rx_mark;
  assign zero_restart = line_bit_en & rx_mark;

  run_counter low_run_cnt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .step    (low_step),
    .restart (low_restart),
    .count   (low_run)
  );

  run_counter zero_run_cnt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .step    (zero_step),
    .restart (zero_restart),
    .count   (zero_run)
  );

  // main next-state logic
  always_comb begin
    logic [5:0]                       wr_idx;
    logic [5:0]                       rd_idx;
    logic                             do_wr;
    logic                             wr_hit;
    logic                             wr_lane;
    logic [7:0]                       line_clr;
    logic [7:0]                       error_clr;
    logic [7:0]                       line_set;
    logic [7:0]                       error_set;
    logic [line_maint_pkg::RUN_W-1:0] loss_limit;
    logic [line_maint_pkg::RUN_W-1:0] zero_limit;
    logic                             declare;
    logic                             zero_err;
    logic                             long_zero;
    logic                             clear_ok;
    logic                             win_ok;
    logic [7:0]                       win_marks;
    logic                             transfer;
    logic                             count_ov;
    logic [15:0]                      cnt_base;
    s_next    = s_reg;
    wr_idx    = s_reg.aw_addr[7:2];
    rd_idx    = s_axi_araddr[7:2];
    do_wr     = s_reg.aw_held & s_reg.w_held & ~s_reg.bvalid;
    wr_lane   = s_reg.w_strb0;
    wr_hit    = 1'b0;
    line_clr  = 8'h00;
    error_clr = 8'h00;
    line_set  = 8'h00;
    error_set = 8'h00;
    clear_ok  = 1'b0;
    win_ok    = s_reg.window_ok;
    win_marks = s_reg.window_marks;
    transfer  = 1'b0;
    count_ov  = 1'b0;
    cnt_base  = s_reg.zero_counter;

    // loss run length by criterion
    if (s_reg.los_criteria[line_maint_pkg::BIT_LOSS_CRIT]) begin
      loss_limit = line_maint_pkg::LOSS_RUN_LONG - 11'd1;
    end else begin
      loss_limit = line_maint_pkg::LOSS_RUN_SHORT - 11'd1;
    end
    // zero limit by line code and criterion
    if (!s_reg.rx_config[line_maint_pkg::BIT_LINE_CODE]) begin
      zero_limit = line_maint_pkg::ZERO_B8ZS;
    end else if (s_reg.error_counting[line_maint_pkg::BIT_ZERO_CRIT]) begin
      zero_limit = line_maint_pkg::ZERO_AMI_FCC;
    end else begin
      zero_limit = line_maint_pkg::ZERO_AMI_ANSI;
    end
    declare   = low_step & (low_run == loss_limit);
    zero_err  = zero_step & (zero_run == zero_limit);
    long_zero = zero_step & (zero_run == (line_maint_pkg::CLEAR_ZERO_RUN - 11'd1));

    if (ce) begin
      // write address and data taken independently
      if (s_axi_awvalid && s_axi_awready) begin
        s_next.aw_held = 1'b1;
        s_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_next.w_held  = 1'b1;
        s_next.w_data  = s_axi_wdata[7:0];
        s_next.w_strb0 = s_axi_wstrb[0];
      end
      if (s_reg.bvalid && s_axi_bready) begin
        s_next.bvalid = 1'b0;
      end

      // register writes once both halves are held
      if (do_wr) begin
        wr_hit = 1'b1;
        if (wr_idx == line_maint_pkg::IDX_RX_CONFIG) begin
          if (wr_lane) s_next.rx_config = s_reg.w_data & line_maint_pkg::MASK_RX_CONFIG;
        end else if (wr_idx == line_maint_pkg::IDX_RX_LEVEL) begin
          if (wr_lane) s_next.rx_level = s_reg.w_data & line_maint_pkg::MASK_RX_LEVEL;
        end else if (wr_idx == line_maint_pkg::IDX_LOOPBACK) begin
          if (wr_lane) s_next.loopback = s_reg.w_data & line_maint_pkg::MASK_LOOPBACK;
        end else if (wr_idx == line_maint_pkg::IDX_LOS_CRITERIA) begin
          if (wr_lane) s_next.los_criteria = s_reg.w_data & line_maint_pkg::MASK_LOS_CRITERIA;
        end else if (wr_idx == line_maint_pkg::IDX_ERROR_COUNTING) begin
          if (wr_lane) s_next.error_counting = s_reg.w_data & line_maint_pkg::MASK_ERROR_COUNT;
        end else if (wr_idx == line_maint_pkg::IDX_TERMINATION) begin
          if (wr_lane) s_next.termination = s_reg.w_data & line_maint_pkg::MASK_TERMINATION;
        end else if (wr_idx == line_maint_pkg::IDX_LINE_IRQ_EN) begin
          if (wr_lane) s_next.line_irq_en = s_reg.w_data & line_maint_pkg::MASK_LINE_IRQ;
        end else if (wr_idx == line_maint_pkg::IDX_ERROR_IRQ_EN) begin
          if (wr_lane) s_next.error_irq_en = s_reg.w_data & line_maint_pkg::MASK_ERROR_IRQ;
        end else if (wr_idx == line_maint_pkg::IDX_LINE_IRQ_ST) begin
          if (wr_lane) line_clr = s_reg.w_data & line_maint_pkg::MASK_LINE_IRQ;
        end else if (wr_idx == line_maint_pkg::IDX_ERROR_IRQ_ST) begin
          if (wr_lane) error_clr = s_reg.w_data & line_maint_pkg::MASK_ERROR_IRQ;
        end else if ((wr_idx == line_maint_pkg::IDX_LINE_STATUS) ||
                     (wr_idx == line_maint_pkg::IDX_COUNT_LOW) ||
                     (wr_idx == line_maint_pkg::IDX_COUNT_HIGH)) begin
          wr_hit = 1'b1;  // read-only, write ignored
        end else begin
          wr_hit = 1'b0;
        end
        s_next.aw_held = 1'b0;
        s_next.w_held  = 1'b0;
        s_next.bvalid  = 1'b1;
        s_next.bresp   = wr_hit ? line_maint_pkg::RESP_OKAY : line_maint_pkg::RESP_SLVERR;
      end

      // register reads
      if (s_reg.rvalid && s_axi_rready) begin
        s_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_next.rvalid = 1'b1;
        s_next.rresp  = line_maint_pkg::RESP_OKAY;
        if (rd_idx == line_maint_pkg::IDX_RX_CONFIG) begin
          s_next.rdata = s_reg.rx_config;
        end else if (rd_idx == line_maint_pkg::IDX_RX_LEVEL) begin
          s_next.rdata = s_reg.rx_level;
        end else if (rd_idx == line_maint_pkg::IDX_LOOPBACK) begin
          s_next.rdata = s_reg.loopback;
        end else if (rd_idx == line_maint_pkg::IDX_LOS_CRITERIA) begin
          s_next.rdata = s_reg.los_criteria;
        end else if (rd_idx == line_maint_pkg::IDX_ERROR_COUNTING) begin
          s_next.rdata = s_reg.error_counting;
        end else if (rd_idx == line_maint_pkg::IDX_TERMINATION) begin
          s_next.rdata = s_reg.termination;
        end else if (rd_idx == line_maint_pkg::IDX_LINE_IRQ_EN) begin
          s_next.rdata = s_reg.line_irq_en;
        end else if (rd_idx == line_maint_pkg::IDX_ERROR_IRQ_EN) begin
          s_next.rdata = s_reg.error_irq_en;
        end else if (rd_idx == line_maint_pkg::IDX_LINE_STATUS) begin
          s_next.rdata = {5'h00, s_reg.driver_fail_d, 1'b0, s_reg.loss_status};
        end else if (rd_idx == line_maint_pkg::IDX_LINE_IRQ_ST) begin
          s_next.rdata = s_reg.line_irq_st;
        end else if (rd_idx == line_maint_pkg::IDX_ERROR_IRQ_ST) begin
          s_next.rdata = s_reg.error_irq_st;
        end else if (rd_idx == line_maint_pkg::IDX_COUNT_LOW) begin
          s_next.rdata = s_reg.zero_report[7:0];
        end else if (rd_idx == line_maint_pkg::IDX_COUNT_HIGH) begin
          s_next.rdata = s_reg.zero_report[15:8];
        end else begin
          s_next.rdata = 8'h00;
          s_next.rresp = line_maint_pkg::RESP_SLVERR;
        end
      end

      // loss clear window of 128 bit periods
      if (line_bit_en) begin
        win_ok    = s_reg.window_ok & rx_level_high & ~long_zero;
        win_marks = s_reg.window_marks + {7'h00, rx_mark};
        if (s_reg.window_pos == line_maint_pkg::WINDOW_LAST) begin
          clear_ok = win_ok & (win_marks >= line_maint_pkg::WINDOW_MARKS);
          s_next.window_pos   = 7'd0;
          s_next.window_ok    = 1'b1;
          s_next.window_marks = 8'h00;
        end else begin
          s_next.window_pos   = s_reg.window_pos + 7'd1;
          s_next.window_ok    = win_ok;
          s_next.window_marks = win_marks;
        end
      end

      // loss declare and clear
      if (declare) begin
        s_next.loss_status = 1'b1;
      end else if (clear_ok) begin
        s_next.loss_status = 1'b0;
      end

      // all-ones substitution on loss
      if (line_bit_en) begin
        s_next.rx_data_q = rx_mark |
          (s_reg.los_criteria[line_maint_pkg::BIT_RX_ONES] & s_reg.loss_status);
        s_next.tx_data_q = tx_data_in |
          (s_reg.los_criteria[line_maint_pkg::BIT_TX_ONES] & s_reg.loss_status);
      end

      // one violation per rising edge of the insert bit
      s_next.viol_pulse = s_next.error_counting[line_maint_pkg::BIT_VIOL_INSERT] &
                          ~s_reg.error_counting[line_maint_pkg::BIT_VIOL_INSERT];

      // counter transfer: manual edge or one-second tick
      if (s_reg.error_counting[line_maint_pkg::BIT_REPORT_MODE]) begin
        transfer = one_sec_tick;
      end else begin
        transfer = s_next.error_counting[line_maint_pkg::BIT_TRANSFER] &
                   ~s_reg.error_counting[line_maint_pkg::BIT_TRANSFER];
      end
      if (transfer) begin
        s_next.zero_report = s_reg.zero_counter;
        cnt_base           = 16'h0000;
      end
      s_next.zero_counter = cnt_base;
      if (zero_err && (s_reg.error_counting[line_maint_pkg::BIT_ZCNT_HI:line_maint_pkg::BIT_ZCNT_LO] ==
                       line_maint_pkg::ZCNT_ENABLE)) begin
        s_next.zero_counter = cnt_base + 16'h0001;
        count_ov            = (cnt_base == 16'hffff);
      end

      // sticky status flags, set wins over clear
      s_next.driver_fail_d = line_events.driver_fail;
      line_set[line_maint_pkg::BIT_DRIVER_FAIL] = line_events.driver_fail & ~s_reg.driver_fail_d;
      line_set[line_maint_pkg::BIT_LOSS]        = s_next.loss_status & ~s_reg.loss_status;
      error_set[line_maint_pkg::BIT_TEMPLATE_OV] = line_events.template_overflow;
      error_set[line_maint_pkg::BIT_TX_SLIP]     = line_events.tx_fifo_slip;
      error_set[line_maint_pkg::BIT_RX_SLIP]     = line_events.rx_fifo_slip;
      error_set[line_maint_pkg::BIT_ZERO_ERR]    = zero_err;
      error_set[line_maint_pkg::BIT_VIOLATION]   = line_events.violation_detect;
      error_set[line_maint_pkg::BIT_COUNT_OV]    = count_ov;
      s_next.line_irq_st  = (s_reg.line_irq_st & ~line_clr) | line_set;
      s_next.error_irq_st = (s_reg.error_irq_st & ~error_clr) | error_set;
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg             <= '0;
      s_reg.rx_level    <= line_maint_pkg::RST_RX_LEVEL;
      s_reg.termination <= line_maint_pkg::RST_TERMINATION;
      s_reg.window_ok   <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // bus handshakes
  assign s_axi_awready = ~s_reg.aw_held & ~s_reg.bvalid;
  assign s_axi_wready  = ~s_reg.w_held & ~s_reg.bvalid;
  assign s_axi_bvalid  = s_reg.bvalid;
  assign s_axi_bresp   = s_reg.bresp;
  assign s_axi_arready = ~s_reg.rvalid;
  assign s_axi_rvalid  = s_reg.rvalid;
  assign s_axi_rresp   = s_reg.rresp;
  assign s_axi_rdata   = {24'h000000, s_reg.rdata};

  // loopback enables
  assign loop_ctrl.system_remote_loop_en  = s_reg.loopback[line_maint_pkg::BIT_SYS_REMOTE];
  assign loop_ctrl.remote_loop_en         = s_reg.loopback[line_maint_pkg::BIT_REMOTE];
  assign loop_ctrl.analog_loop_en         = s_reg.loopback[line_maint_pkg::BIT_ANALOG];
  assign loop_ctrl.local_digital_loop2_en = s_reg.loopback[line_maint_pkg::BIT_DIGITAL2];

  // termination selection
  assign term_ctrl.tx_term          = s_reg.termination[5:3];
  assign term_ctrl.tx_term_reserved = s_reg.termination[5];
  assign term_ctrl.rx_term          = s_reg.termination[2:0];
  assign term_ctrl.rx_term_bypass   = s_reg.termination[2];

  // line data and status
  assign loss_threshold_q       = s_reg.rx_level[4:0];
  assign loss_status            = s_reg.loss_status;
  assign rx_data_out            = s_reg.rx_data_q;
  assign tx_data_out            = s_reg.tx_data_q;
  assign violation_insert_pulse = s_reg.viol_pulse;

  // interrupt: any flag with its enable
  assign irq = (|(s_reg.line_irq_st & s_reg.line_irq_en)) |
               (|(s_reg.error_irq_st & s_reg.error_irq_en));

endmodule : line_maintenance_interrupt_ctrl

// [verification/line_partner.sv]
`timescale 1ns/1ps
module line_partner (
  // clock and line condition
  input  wire logic                    aclk, lost,
  // line outputs
  output logic                         line_bit_en, rx_level_low, rx_level_high, rx_mark, tx_data_in, one_sec_tick,
  output line_maint_pkg::line_events_t line_events
);
  logic ph = 1'b0;
  // alternating marks keep density far above one in eight
  always @(posedge aclk) ph <= ~ph;
  assign line_bit_en   = 1'b1;
  // level low while lost, marks only while signal present
  assign rx_level_low  = lost;
  assign rx_level_high = ~lost;
  assign rx_mark       = ph & ~lost;
  assign tx_data_in    = ~ph;
  assign one_sec_tick  = 1'b0;
  assign line_events   = '0;
endmodule : line_partner

// [verification/line_maintenance_interrupt_ctrl_checker.sv]
`timescale 1ns/1ps
module line_maint_checker (
  // clock, reset, bus handshakes
  input wire logic                       aclk, aresetn, s_axi_bvalid, s_axi_bready, s_axi_rvalid, s_axi_rready,
  input wire logic                       s_axi_arready,
  // line side
  input wire logic                       line_bit_en, loss_status, rx_level_low, rx_mark, rx_data_out,
  input wire logic                       tx_data_in, tx_data_out, violation_insert_pulse,
  input wire line_maint_pkg::term_ctrl_t term_ctrl
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // bus answers stand until taken
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready during rvalid");
  // line data passes unchanged without loss
  chk_rx_pass: assert property (aresetn && line_bit_en && !loss_status |=> rx_data_out == $past(rx_mark))
    else $error("rx data altered");
  chk_tx_pass: assert property (aresetn && line_bit_en && !loss_status |=> tx_data_out == $past(tx_data_in))
    else $error("tx data altered");
  chk_viol_once: assert property (violation_insert_pulse |=> !violation_insert_pulse [*2])
    else $error("extra violation");
  chk_loss_run: assert property ($rose(loss_status) |-> $past(rx_level_low, 1) && $past(rx_level_low, 175))
    else $error("loss declared early");
  chk_loss_hold: assert property (loss_status && rx_level_low |=> loss_status)
    else $error("loss cleared at low level");
  chk_term_flags: assert property (term_ctrl.tx_term_reserved == term_ctrl.tx_term[2] &&
    term_ctrl.rx_term_bypass == term_ctrl.rx_term[2]) else $error("termination flags wrong");
endmodule : line_maint_checker
bind line_maintenance_interrupt_ctrl line_maint_checker u_chk (.*);

// [verification/tb_line_maintenance_interrupt_ctrl.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_line_maintenance_interrupt_ctrl;
  // bus side
  logic        aclk = 0, aresetn = 0, ce = 1, lost = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, d;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  // line side
  logic        line_bit_en, rx_level_low, rx_level_high, rx_mark, tx_data_in, one_sec_tick;
  logic        rx_data_out, tx_data_out, violation_insert_pulse, loss_status, irq;
  logic [4:0]  loss_threshold_q;
  line_maint_pkg::line_events_t line_events;
  line_maint_pkg::loop_ctrl_t   loop_ctrl;
  line_maint_pkg::term_ctrl_t   term_ctrl;
  logic [5:0]  ix [4] = '{6'h2b, 6'h32, 6'h33, 6'h34};
  logic [7:0]  mk [4] = '{8'h17, 8'h3f, 8'h05, 8'h77};
  int          miscompares = 0, num_checks = 0, cyc = 0, vcnt = 0;
  line_maintenance_interrupt_ctrl u_dut (.*);
  line_partner u_line (.*);
  always #25 aclk = ~aclk;
  // timeout and violation pulse count
  always @(posedge aclk) begin
    cyc++;
    vcnt += violation_insert_pulse;
    if (cyc == 8000) begin
      miscompares++;
      end_of_test();
    end
  end
  task wt(input int n); repeat (n) @(posedge aclk); endtask : wt
  // axi4-lite write, each channel released when taken; ready waits a cycle to exercise the hold
  task wr(input logic [5:0] i, input logic [7:0] v);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h000000, v};
    {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
  endtask : wr
  task rd(input logic [5:0] i);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task rc(input logic [5:0] i, input logic [7:0] e); rd(i); `CHK("rdata", e, d) endtask : rc
  task end_of_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // main sequence
  initial begin
    wt(20);
    aresetn <= 1'b1;
    wt(1);
    rc(6'h31, 8'h00);
    rc(6'h32, 8'h04);
    rc(6'h33, 8'h00);
    rc(6'h34, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(ix[k], 8'hff);
      rc(ix[k], mk[k]);
    end
    `CHK("loop", 4'hf, loop_ctrl)
    `CHK("tres", 1'b1, term_ctrl.tx_term_reserved)
    `CHK("lvl", 5'h15, loss_threshold_q)
    rd(6'h00);
    `CHK("rresp", line_maint_pkg::RESP_SLVERR, r)
    wr(6'h31, 8'h40);
    wr(6'h31, 8'h00);
    `CHK("viol", 1, vcnt)
    $display("test regs done");
    wr(6'h2c, 8'h00);
    lost <= 1'b1;
    wt(173);
    `CHK("loss", 1'b0, loss_status)
    wt(3);
    `CHK("loss", 1'b1, loss_status)
    `CHK("rx", 1'b0, rx_data_out)
    wr(6'h2c, 8'h0c);
    wt(1);
    `CHK("rx", 1'b1, rx_data_out)
    `CHK("tx", 1'b1, tx_data_out)
    wt(1);
    `CHK("tx", 1'b1, tx_data_out)
    `CHK("irq", 1'b1, irq)
    rc(6'h3a, 8'h01);
    rc(6'h3b, 8'h04);
    wr(6'h3a, 8'hff);
    wr(6'h3b, 8'hff);
    `CHK("irq", 1'b0, irq)
    $display("test loss done");
    lost <= 1'b0;
    wt(300);
    `CHK("loss", 1'b0, loss_status)
    wr(6'h31, 8'h04);
    wr(6'h2c, 8'h10);
    lost <= 1'b1;
    wt(1542);
    `CHK("loss", 1'b0, loss_status)
    wt(3);
    `CHK("loss", 1'b1, loss_status)
    wr(6'h31, 8'h05);
    rc(6'h3c, 8'h01);
    rc(6'h3d, 8'h00);
    $display("test count done");
    end_of_test();
  end
endmodule : tb_line_maintenance_interrupt_ctrl
